/* shared/e1arm_pkg.sv */
// Behaviour
// RULE_01 - Below minor threshold: no alarm outputs
// RULE_02 - Minor level: contact, LED, log message
// RULE_03 - Major adds line conditioning, yellow alarm
// RULE_04 - Conditioning sends all on- or off-hook
// RULE_05 - Threshold codes 3..9 only, else invalid
// RULE_06 - Code n means ten to minus n
// RULE_07 - Major code must be smaller than minor; the monitor does not check this
// RULE_08 - Durations 1..3600 s, range per code
// RULE_09 - Error counter saturates at 65000
// RULE_10 - Declare alarm early once count exceeded
// RULE_11 - On activation clear counter, restart window
// RULE_12 - Condition ends after clean full window
// RULE_13 - Self-clear auto clears; else wait command
// RULE_14 - Clear opens contact, LED off, logs
// RULE_15 - Manual mode: supervision stops when condition ends
// RULE_16 - Slip count over threshold raises major
// RULE_17 - Slip threshold 1..255, period 1..24 h
// RULE_18 - Factory defaults 6/10s, 5/10s, 5 slips, 2 h
// RULE_19 - Empty entry keeps stored value
// RULE_20 - Operators should use 10 s durations
// RULE_21 - Self-clearing defaults to enabled
// RULE_22 - One-second tick drives all timing
// RULE_23 - Clear request is one-cycle pulse
`default_nettype none
package e1arm_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned TICK_CYCLES = CLK_HZ;
	localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
	localparam logic [15:0] ERR_SAT = 16'hFDE8;
	localparam logic [3:0] CODE_MIN = 4'h3;
	localparam logic [3:0] CODE_MAX = 4'h9;
	localparam logic [11:0] DUR_MAX = 12'hE10;
	localparam logic [16:0] SEC_PER_HOUR = 17'h00E10;
	localparam logic [3:0] DEF_MIN_CODE = 4'h6;
	localparam logic [11:0] DEF_MIN_DUR = 12'h00A;
	localparam logic [3:0] DEF_MAJ_CODE = 4'h5;
	localparam logic [11:0] DEF_MAJ_DUR = 12'h00A;
	localparam logic [7:0] DEF_SLIP_THR = 8'h05;
	localparam logic [4:0] DEF_SLIP_HRS = 5'h02;
	localparam logic DEF_SELF_CLEAR = 1'b1;
	localparam logic [4:0] SLIP_HRS_MAX = 5'h18;
	typedef enum logic [1:0] {E1ARM_NONE, E1ARM_MINOR, E1ARM_MAJOR} e1arm_level_t;
endpackage : e1arm_pkg
`default_nettype wire

/* rtl/e1arm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module e1arm_monitor import e1arm_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bitErrorPulse,
	input wire logic frameSlipPulse,
	input wire logic offHookSelect,
	input wire logic cfgWrite,
	input wire logic [3:0] cfgMinCode,
	input wire logic [11:0] cfgMinDur,
	input wire logic [3:0] cfgMajCode,
	input wire logic [11:0] cfgMajDur,
	input wire logic [7:0] cfgSlipThr,
	input wire logic [4:0] cfgSlipHrs,
	input wire logic [5:0] cfgKeep,
	input wire logic cfgSelfClear,
	input wire logic cfgSelfClearKeep,
	input wire logic clearAlarm,
	output logic paramInvalid,
	output logic [3:0] curMinCode,
	output logic [11:0] curMinDur,
	output logic [3:0] curMajCode,
	output logic [11:0] curMajDur,
	output logic [7:0] curSlipThr,
	output logic [4:0] curSlipHrs,
	output logic curSelfClear,
	output logic [1:0] alarmLevel,
	output logic alarmContact,
	output logic alarmLed,
	output logic lineConditioning,
	output logic [3:0] conditioningBits,
	output logic yellowAlarm,
	output logic logRaise,
	output logic logClear
);
	// ***************************************************
	// Input synchronisers and edge detection
	// ***************************************************
	logic [2:0] errSync_r;
	logic [2:0] slipSync_r;
	logic [1:0] hookSync_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			errSync_r <= 3'h0;
			slipSync_r <= 3'h0;
			hookSync_r <= 2'h0;
		end else begin
			errSync_r <= {errSync_r[1:0], bitErrorPulse};
			slipSync_r <= {slipSync_r[1:0], frameSlipPulse};
			hookSync_r <= {hookSync_r[0], offHookSelect};
		end
	end
	logic errEvt;
	logic slipEvt;
	assign errEvt = errSync_r[1] & ~errSync_r[2];
	assign slipEvt = slipSync_r[1] & ~slipSync_r[2];

	// ***************************************************
	// One-second tick
	// ***************************************************
	logic [23:0] tickCnt_r;
	logic secTick;
	assign secTick = (tickCnt_r == TICK_LAST); // see RULE_22
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt_r <= 24'h000000;
		end else begin
			tickCnt_r <= secTick ? 24'h000000 : tickCnt_r + 24'h000001;
		end
	end

	// ***************************************************
	// Configuration
	// ***************************************************
	function automatic logic durOk(input logic [3:0] code, input logic [11:0] dur);
		logic [11:0] lo;
		logic [11:0] hi;
		lo = 12'h001;
		hi = DUR_MAX;
		unique case (code)
			4'h3: hi = 12'h015;
			4'h4: hi = 12'h0DA;
			4'h5: hi = 12'h864;
			4'h7: lo = 12'h00A;
			4'h8: lo = 12'h064;
			4'h9: lo = 12'h3E8;
			default: lo = 12'h001;
		endcase
		return (dur >= lo) && (dur <= hi); // see RULE_08
	endfunction : durOk

	logic [3:0] newMinCode;
	logic [11:0] newMinDur;
	logic [3:0] newMajCode;
	logic [11:0] newMajDur;
	logic [7:0] newSlipThr;
	logic [4:0] newSlipHrs;
	logic cfgBad;
	always_comb begin
		// Empty entry keeps the stored value
		newMinCode = cfgKeep[0] ? curMinCode : cfgMinCode; // see RULE_19
		newMinDur = cfgKeep[1] ? curMinDur : cfgMinDur;
		newMajCode = cfgKeep[2] ? curMajCode : cfgMajCode;
		newMajDur = cfgKeep[3] ? curMajDur : cfgMajDur;
		newSlipThr = cfgKeep[4] ? curSlipThr : cfgSlipThr;
		newSlipHrs = cfgKeep[5] ? curSlipHrs : cfgSlipHrs;
		cfgBad = (newMinCode < CODE_MIN) || (newMinCode > CODE_MAX)
			|| (newMajCode < CODE_MIN) || (newMajCode > CODE_MAX); // see RULE_05
		cfgBad = cfgBad || !durOk(newMinCode, newMinDur) || !durOk(newMajCode, newMajDur);
		cfgBad = cfgBad || (newSlipThr == 8'h00)
			|| (newSlipHrs == 5'h00) || (newSlipHrs > SLIP_HRS_MAX); // see RULE_17
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			curMinCode <= DEF_MIN_CODE; // see RULE_18
			curMinDur <= DEF_MIN_DUR;
			curMajCode <= DEF_MAJ_CODE;
			curMajDur <= DEF_MAJ_DUR;
			curSlipThr <= DEF_SLIP_THR;
			curSlipHrs <= DEF_SLIP_HRS;
			curSelfClear <= DEF_SELF_CLEAR; // see RULE_21
			paramInvalid <= 1'b0;
		end else begin
			paramInvalid <= 1'b0;
			if (cfgWrite) begin
				if (!cfgSelfClearKeep)
					curSelfClear <= cfgSelfClear;
				if (cfgBad) begin
					paramInvalid <= 1'b1; // see RULE_05
				end else begin
					curMinCode <= newMinCode;
					curMinDur <= newMinDur;
					curMajCode <= newMajCode;
					curMajDur <= newMajDur;
					curSlipThr <= newSlipThr;
					curSlipHrs <= newSlipHrs;
				end
			end
		end
	end

	// ***************************************************
	// Allowed error count per window
	// ***************************************************
	// Code n: 2*10^(6-n) errors per second; scaled by window seconds
	function automatic logic [31:0] allowed(input logic [3:0] code, input logic [11:0] dur);
		logic [31:0] d;
		d = {20'h00000, dur};
		unique case (code)
			4'h3: allowed = d * 32'd2000;
			4'h4: allowed = d * 32'd200;
			4'h5: allowed = d * 32'd20;
			4'h6: allowed = d * 32'd2;
			4'h7: allowed = (d * 32'd2) / 32'd10;
			4'h8: allowed = (d * 32'd2) / 32'd100;
			default: allowed = (d * 32'd2) / 32'd1000;
		endcase // see RULE_06
	endfunction : allowed

	// ***************************************************
	// Per-level window evaluation
	// ***************************************************
	logic [15:0] errCnt_r [2];
	logic [11:0] secCnt_r [2];
	logic cond_r [2];
	logic [1:0] declare;
	logic [11:0] winDur [2];
	logic [31:0] limit [2];
	assign winDur[0] = curMinDur;
	assign winDur[1] = curMajDur;
	assign limit[0] = allowed(curMinCode, curMinDur);
	assign limit[1] = allowed(curMajCode, curMajDur);

	for (genvar i = 0; i < 2; i++) begin : gLevel
		assign declare[i] = ({16'h0000, errCnt_r[i]} > limit[i]); // see RULE_10
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				errCnt_r[i] <= 16'h0000;
				secCnt_r[i] <= 12'h000;
				cond_r[i] <= 1'b0;
			end else if (declare[i]) begin
				errCnt_r[i] <= 16'h0000; // see RULE_11
				secCnt_r[i] <= 12'h000;
				cond_r[i] <= 1'b1; // see RULE_12
			end else begin
				if (errEvt && errCnt_r[i] != ERR_SAT)
					errCnt_r[i] <= errCnt_r[i] + 16'h0001; // see RULE_09
				if (secTick) begin
					if (secCnt_r[i] + 12'h001 >= winDur[i]) begin
						// Clean window ends the condition
						secCnt_r[i] <= 12'h000;
						// An error on the window edge counts in the next window
						errCnt_r[i] <= errEvt ? 16'h0001 : 16'h0000;
						cond_r[i] <= 1'b0; // see RULE_12
					end else begin
						secCnt_r[i] <= secCnt_r[i] + 12'h001;
					end
				end
			end
		end
	end

	// ***************************************************
	// Frame slips
	// ***************************************************
	logic [7:0] slipCnt_r;
	logic [16:0] slipSec_r;
	logic [4:0] slipHr_r;
	logic slipAlarm_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slipCnt_r <= 8'h00;
			slipSec_r <= 17'h00000;
			slipHr_r <= 5'h00;
			slipAlarm_r <= 1'b0;
		end else begin
			if (slipEvt && slipCnt_r != 8'hFF)
				slipCnt_r <= slipCnt_r + 8'h01;
			if (slipCnt_r > curSlipThr)
				slipAlarm_r <= 1'b1; // see RULE_16
			if (secTick) begin
				if (slipSec_r + 17'h00001 >= SEC_PER_HOUR) begin
					slipSec_r <= 17'h00000;
					if (slipHr_r + 5'h01 >= curSlipHrs) begin
						slipHr_r <= 5'h00;
						// A slip on the period edge counts in the new period
						slipCnt_r <= slipEvt ? 8'h01 : 8'h00; // see RULE_17
						slipAlarm_r <= 1'b0;
					end else begin
						slipHr_r <= slipHr_r + 5'h01;
					end
				end else begin
					slipSec_r <= slipSec_r + 17'h00001;
				end
			end
		end
	end

	// ***************************************************
	// Alarm outputs
	// ***************************************************
	logic majorCond;
	logic anyCond;
	assign majorCond = cond_r[1] | slipAlarm_r;
	assign anyCond = cond_r[0] | majorCond;
	logic indic_r;
	logic indicMajor_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			indic_r <= 1'b0;
			indicMajor_r <= 1'b0;
			logRaise <= 1'b0;
			logClear <= 1'b0;
		end else begin
			logRaise <= 1'b0;
			logClear <= 1'b0;
			if (anyCond) begin
				indic_r <= 1'b1; // see RULE_02
				indicMajor_r <= indicMajor_r | majorCond;
				logRaise <= !indic_r || (majorCond && !indicMajor_r);
			end else if (indic_r && (curSelfClear || clearAlarm)) begin // see RULE_13
				indic_r <= 1'b0;
				indicMajor_r <= 1'b0;
				logClear <= 1'b1; // see RULE_14
			end
		end
	end
	always_comb begin
		alarmContact = indic_r; // see RULE_01
		alarmLed = indic_r;
		// Supervision follows the live condition even when latched
		lineConditioning = majorCond; // see RULE_03
		yellowAlarm = majorCond; // see RULE_15
		conditioningBits = majorCond ? (hookSync_r[1] ? 4'hF : 4'h0) : 4'h0; // see RULE_04
		if (indicMajor_r)
			alarmLevel = 2'(E1ARM_MAJOR);
		else if (indic_r)
			alarmLevel = 2'(E1ARM_MINOR);
		else
			alarmLevel = 2'(E1ARM_NONE);
	end
endmodule : e1arm_monitor
`default_nettype wire

/* dv/e1arm_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Line side: raw error and slip edges, launched on the monitor clock
// ****
module e1arm_line_model (
	input wire logic clk,
	output logic bitErrorPulse,
	output logic frameSlipPulse
);
	initial begin
		bitErrorPulse = 1'b0;
		frameSlipPulse = 1'b0;
	end
	// Pulses held 2 cycles so the 2-FF sync never drops one
	task automatic sendErrors(input int n, input int gap);
		repeat (n) begin
			@(posedge clk) bitErrorPulse <= 1'b1;
			repeat (2) @(posedge clk);
			bitErrorPulse <= 1'b0;
			repeat (gap) @(posedge clk);
		end
	endtask : sendErrors
	task automatic sendSlips(input int n, input int gap);
		repeat (n) begin
			@(posedge clk) frameSlipPulse <= 1'b1;
			repeat (2) @(posedge clk);
			frameSlipPulse <= 1'b0;
			repeat (gap) @(posedge clk);
		end
	endtask : sendSlips
endmodule : e1arm_line_model
`default_nettype wire

/* dv/e1arm_alarm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module e1arm_alarm_monitor import e1arm_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cfgWrite,
	input wire logic clearAlarm,
	input wire logic offHookSelect,
	input wire logic paramInvalid,
	input wire logic [3:0] curMinCode,
	input wire logic [11:0] curMinDur,
	input wire logic [3:0] curMajCode,
	input wire logic [7:0] curSlipThr,
	input wire logic [4:0] curSlipHrs,
	input wire logic [1:0] alarmLevel,
	input wire logic alarmContact,
	input wire logic alarmLed,
	input wire logic lineConditioning,
	input wire logic [3:0] conditioningBits,
	input wire logic yellowAlarm,
	input wire logic logRaise
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_invalid_cause: assert property (paramInvalid |-> $past(cfgWrite))
		else $error("paramInvalid without a write");
	chk_cur_hold: assert property (!$past(cfgWrite) |->
		$stable({curMinCode, curMajCode, curMinDur, curSlipThr, curSlipHrs}))
		else $error("stored value moved without a write");
	chk_code_range: assert property (curMinCode inside {[CODE_MIN:CODE_MAX]} &&
		curMajCode inside {[CODE_MIN:CODE_MAX]}) else $error("stored code out of range");
	chk_slip_range: assert property (curSlipThr != 8'h00 && curMinDur inside {[12'h001:DUR_MAX]} &&
		curSlipHrs inside {[5'h01:SLIP_HRS_MAX]}) else $error("stored slip or duration out of range");
	chk_raise_log: assert property ($rose(alarmContact) |-> logRaise)
		else $error("contact closed without log entry");
	chk_led_contact: assert property (alarmLed == alarmContact)
		else $error("LED and contact disagree");
	chk_level_none: assert property (alarmLevel == 2'h0 |-> !alarmContact)
		else $error("contact closed at no-alarm level");
	chk_yellow_cond: assert property (yellowAlarm == lineConditioning)
		else $error("yellow alarm and conditioning disagree");
	chk_cond_major: assert property (lineConditioning |=> alarmContact && alarmLevel == 2'h2)
		else $error("conditioning without major indication");
	chk_bits_idle: assert property (!lineConditioning |-> conditioningBits == 4'h0)
		else $error("signalling forced outside conditioning");
	chk_bits_off: assert property (offHookSelect [*4] ##0 lineConditioning |-> conditioningBits == 4'hF)
		else $error("off-hook not presented");
	chk_bits_on: assert property (!offHookSelect [*4] ##0 lineConditioning |-> conditioningBits == 4'h0)
		else $error("on-hook not presented");
	chk_clear_ignore: assert property (clearAlarm && lineConditioning |=> alarmContact)
		else $error("clear honoured during live condition");
	cover property (logRaise);
	cover property (paramInvalid);
	cover property (lineConditioning && conditioningBits == 4'hF);
endmodule : e1arm_alarm_monitor
bind e1arm_monitor e1arm_alarm_monitor chk (.clk(clk), .rst_b(rst_b), .cfgWrite(cfgWrite),
	.clearAlarm(clearAlarm), .offHookSelect(offHookSelect), .paramInvalid(paramInvalid),
	.curMinCode(curMinCode), .curMinDur(curMinDur), .curMajCode(curMajCode),
	.curSlipThr(curSlipThr), .curSlipHrs(curSlipHrs), .alarmLevel(alarmLevel),
	.alarmContact(alarmContact), .alarmLed(alarmLed), .lineConditioning(lineConditioning),
	.conditioningBits(conditioningBits), .yellowAlarm(yellowAlarm), .logRaise(logRaise));
`default_nettype wire

/* dv/e1arm_testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import e1arm_pkg::*;;
	logic clk = 1'b0, rst_b = 1'b0, offHookSelect = 1'b0, cfgWrite = 1'b0, clearAlarm = 1'b0;
	logic cfgSelfClear = 1'b0, cfgSelfClearKeep = 1'b0;
	logic [3:0] cfgMinCode = 4'h6, cfgMajCode = 4'h5, curMinCode, curMajCode, conditioningBits;
	logic [11:0] cfgMinDur = 12'h00A, cfgMajDur = 12'h00A, curMinDur, curMajDur;
	logic [7:0] cfgSlipThr = 8'h05, curSlipThr;
	logic [4:0] cfgSlipHrs = 5'h02, curSlipHrs;
	logic [5:0] cfgKeep = 6'h00;
	logic [1:0] alarmLevel;
	logic bitErrorPulse, frameSlipPulse, paramInvalid, curSelfClear, alarmContact, alarmLed;
	logic lineConditioning, yellowAlarm, logRaise, logClear;
	int errCount = 0, samplesChecked = 0, raiseCount = 0, clearCount = 0;
	always #50 clk = ~clk;
	e1arm_line_model partner (.clk(clk), .bitErrorPulse(bitErrorPulse), .frameSlipPulse(frameSlipPulse));
	e1arm_monitor uut (.clk(clk), .rst_b(rst_b), .bitErrorPulse(bitErrorPulse),
		.frameSlipPulse(frameSlipPulse), .offHookSelect(offHookSelect), .cfgWrite(cfgWrite),
		.cfgMinCode(cfgMinCode), .cfgMinDur(cfgMinDur), .cfgMajCode(cfgMajCode),
		.cfgMajDur(cfgMajDur), .cfgSlipThr(cfgSlipThr), .cfgSlipHrs(cfgSlipHrs),
		.cfgKeep(cfgKeep), .cfgSelfClear(cfgSelfClear), .cfgSelfClearKeep(cfgSelfClearKeep),
		.clearAlarm(clearAlarm), .paramInvalid(paramInvalid), .curMinCode(curMinCode),
		.curMinDur(curMinDur), .curMajCode(curMajCode), .curMajDur(curMajDur),
		.curSlipThr(curSlipThr), .curSlipHrs(curSlipHrs), .curSelfClear(curSelfClear),
		.alarmLevel(alarmLevel), .alarmContact(alarmContact), .alarmLed(alarmLed),
		.lineConditioning(lineConditioning), .conditioningBits(conditioningBits),
		.yellowAlarm(yellowAlarm), .logRaise(logRaise), .logClear(logClear));
	always @(posedge clk) if (logRaise === 1'b1) raiseCount++;
	always @(posedge clk) if (logClear === 1'b1) clearCount++;
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errCount++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic cfg(input logic [3:0] mc, input logic [11:0] md, input logic [3:0] jc,
		input logic [11:0] jd, input logic [7:0] st, input logic [4:0] sh, input logic [5:0] kp);
		@(posedge clk);
		{cfgWrite, cfgMinCode, cfgMinDur, cfgMajCode} <= {1'b1, mc, md, jc};
		{cfgMajDur, cfgSlipThr, cfgSlipHrs, cfgKeep} <= {jd, st, sh, kp};
		@(posedge clk) cfgWrite <= 1'b0;
		#1;
	endtask : cfg
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	task automatic giveVerdict();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, errCount);
		if (errCount == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : giveVerdict
	// ****
	// Test sequence
	// ****
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		settle(1);
		check("defaults", {curMinCode, curMajCode, curSlipThr}, 16'h6505);
		check("durs", {curMinDur, curSlipHrs}, {12'h00A, 5'h02});
		check("majDur", curMajDur, 12'h00A);
		check("selfClear", curSelfClear, 1'b1);
		// Rejected sets: bad code, duration outside code range, slip limits
		for (int i = 0; i < 6; i++) begin
			cfg(i == 0 ? 4'h2 : i == 1 ? 4'hA : i == 3 ? 4'h7 : 4'h4, i == 3 ? 12'h009 : 12'h001,
				4'h3, i == 2 ? 12'h016 : 12'h001, i == 4 ? 8'h00 : 8'h01, i == 5 ? 5'h19 : 5'h01, 6'h00);
			check("invalid", paramInvalid, 1'b1);
			check("keptCode", curMinCode, 4'h6);
		end
		cfg(4'h3, 12'h001, 4'h3, 12'h001, 8'h01, 5'h01, 6'h3F);
		check("emptyEntry", {curMinCode, curMajCode, curSlipThr}, 16'h6505);
		cfg(4'h4, 12'h001, 4'h3, 12'h001, 8'h01, 5'h01, 6'h00);
		check("accepted", {curMinCode, curMajCode, curSlipThr}, 16'h4301);
		check("acceptDur", {curMajDur, curSlipHrs}, {12'h001, 5'h01});
		check("manualMode", curSelfClear, 1'b0);
		// Code 4 over 1 s allows 200 errors; the 201st declares
		partner.sendErrors(200, 2);
		settle(10);
		check("atLimit", alarmLevel, 2'h0);
		partner.sendErrors(1, 2);
		for (int i = 0; i < 20 && alarmContact !== 1'b1; i++) settle(1);
		check("minorLog", logRaise, 1'b1);
		check("minor", {alarmLevel, alarmContact, alarmLed, lineConditioning}, 5'h0E);
		// Counter restarted at declaration, so 200 more stay within
		partner.sendErrors(200, 2);
		settle(10);
		check("restart", raiseCount, 1);
		partner.sendSlips(1, 3);
		settle(10);
		check("slipAtThr", lineConditioning, 1'b0);
		partner.sendSlips(1, 3);
		for (int i = 0; i < 20 && lineConditioning !== 1'b1; i++) settle(1);
		// Level indication latches one cycle after conditioning starts
		settle(1);
		check("major", {alarmLevel, yellowAlarm, conditioningBits}, 7'h50);
		@(posedge clk) offHookSelect <= 1'b1;
		settle(6);
		check("offHook", conditioningBits, 4'hF);
		check("majorLog", raiseCount, 2);
		@(posedge clk) clearAlarm <= 1'b1;
		@(posedge clk) clearAlarm <= 1'b0;
		settle(3);
		check("clearIgnored", alarmContact, 1'b1);
		check("noClearLog", clearCount, 0);
		giveVerdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		errCount++;
		giveVerdict();
	end
endmodule : testbench
`default_nettype wire
